// *** design/hamd_defs.svh ***
`ifndef HAMD_DEFS_SVH
`define HAMD_DEFS_SVH

// Default-mode offsets of the system registers and windows.
`define HAMD_RD_FIFO_LO   12'h000
`define HAMD_RD_FIFO_HI   12'h01C
`define HAMD_WR_FIFO_LO   12'h020
`define HAMD_WR_FIFO_HI   12'h03C
`define HAMD_OFS_ID       12'h050
`define HAMD_OFS_IRQCFG   12'h054
`define HAMD_OFS_IFLAGS   12'h058
`define HAMD_OFS_IMASK    12'h05C
`define HAMD_OFS_ENDIAN   12'h064
`define HAMD_OFS_HWCFG    12'h074
`define HAMD_OFS_PMT      12'h084
`define HAMD_OFS_TCFG     12'h08C
`define HAMD_OFS_TCNT     12'h090
`define HAMD_OFS_FREE     12'h09C
`define HAMD_OFS_RSTCTL   12'h1F8
`define HAMD_OFS_CDATA    12'h300
`define HAMD_OFS_CCMD     12'h304
`define HAMD_OFS_PRD_AL   12'h308
`define HAMD_OFS_PRD_CMD  12'h30C
`define HAMD_OFS_PWR_AL   12'h310
`define HAMD_OFS_PWR_CMD  12'h314
`define HAMD_SYS_DEF_HI   12'h314

// Direct-mapped windows, in host byte addresses.
`define HAMD_CORE_REG_HI  16'h0FFF
`define HAMD_PRAM_LO      16'h1000
`define HAMD_PRAM_HI      16'h2FFF
`define HAMD_SYS_BASE     16'h3000
`define HAMD_SYS_DIR_LO   16'h3050
`define HAMD_SYS_DIR_HI   16'h31FC

// Field positions.
`define HAMD_HWCFG_DIRECT 0
`define HAMD_HWCFG_STRAP  16
`define HAMD_TCFG_EN      29
`define HAMD_CMD_BUSY     31
`define HAMD_RSTCTL_CORE  0

// Reset and constant values.
`define HAMD_CHIP_ID      32'h0000_A5A5
`define HAMD_ENDIAN_PAT   32'h0102_0304
`define HAMD_ZERO32       32'h0000_0000
`define HAMD_TCFG_RST     32'h0000_FFFF
`define HAMD_STRAP_W      4
`define HAMD_STRAP_DELAY  2'h2

`endif

// *** design/hamd_host_address_map_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hamd_defs.svh"

// Summary of operation
// - Capture straps on every reset kind.
// - Strap values taken at reset release.
// - Reset into indirect mode.
// - Direct mode: core registers, then process RAM.
// - Direct mode moves system registers by 3000h.
// - System registers 050h-314h or 3050h-31FCh.
// - Relocated register sits at default plus 3000h.
// - Direct mode hides FIFOs and indirect registers.
// - Read FIFO answers across 000h-01Ch.
// - Write FIFO accepts writes across 020h-03Ch.
// - Core indirect data 300h, command 304h.
// - RAM read setup at 308h and 30Ch.
// - RAM write setup at 310h and 314h.
// - Chip reset restores every register default.
// - Serial and parallel host share offsets.
// - Identity, interrupt and byte-order offsets fixed.
// - Config, power, timer and counter offsets fixed.
module hamd_host_address_map_decoder (
  // Clock and chip-level reset.
  input  wire logic                       mclk_in,
  input  wire logic                       resetn_in,
  // Host access from the parallel host bus or serial port logic.
  input  wire logic                       host_req_in,
  input  wire hamd_pkg::hamd_req_type     host_cmd_in,
  output logic                            host_ack_out,
  output logic [31:0]                     host_rdata_out,
  // Process-RAM data FIFOs.
  input  wire logic [31:0]                rd_fifo_data_in,
  output logic                            rd_fifo_pop_out,
  output logic                            wr_fifo_push_out,
  output logic [31:0]                     wr_fifo_data_out,
  // Direct-mapped access to the slave core.
  output logic                            core_req_out,
  output hamd_pkg::hamd_core_type         core_cmd_out,
  input  wire logic [31:0]                core_rdata_in,
  // Indirect command starts and completions.
  output logic                            ind_cmd_start_out,
  output logic                            pram_rd_start_out,
  output logic                            pram_wr_start_out,
  input  wire logic                       ind_cmd_done_in,
  input  wire logic                       pram_rd_done_in,
  input  wire logic                       pram_wr_done_in,
  // Events, core reset and straps.
  input  wire logic [31:0]                int_event_in,
  input  wire logic                       core_reset_in,
  output logic                            core_reset_out,
  input  wire logic [`HAMD_STRAP_W-1:0]   strap_pins_in,
  output logic [`HAMD_STRAP_W-1:0]        strap_out,
  output logic                            direct_mode_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Classify a host address under the current mode.
  function automatic hamd_pkg::hamd_target_type decode(input logic [15:0] a,
                                                        input logic dm);
    logic [15:0] rel;
    rel = a - `HAMD_SYS_BASE;
    decode = hamd_pkg::TGT_NONE;
    if (dm)
    begin
      if (a <= `HAMD_CORE_REG_HI)
        decode = hamd_pkg::TGT_CORE;
      else if (a <= `HAMD_PRAM_HI)
        decode = hamd_pkg::TGT_PRAM;
      else if (a >= `HAMD_SYS_DIR_LO && a <= `HAMD_SYS_DIR_HI &&
               sys_known(rel[11:0], 1'b1))
        decode = hamd_pkg::TGT_SYS;
    end
    else if (a[15:12] == 4'h0)
    begin
      if (a[11:0] <= `HAMD_RD_FIFO_HI)
        decode = hamd_pkg::TGT_RD_FIFO;
      else if (a[11:0] <= `HAMD_WR_FIFO_HI)
        decode = hamd_pkg::TGT_WR_FIFO;
      else if (sys_known(a[11:0], 1'b0))
        decode = hamd_pkg::TGT_SYS;
    end
  endfunction : decode

  // True for an assigned system register offset; the indirect set is
  // withheld in direct mode because its window no longer exists there.
  function automatic logic sys_known(input logic [11:0] o, input logic dm);
    case (o)
      `HAMD_OFS_ID, `HAMD_OFS_IRQCFG, `HAMD_OFS_IFLAGS, `HAMD_OFS_IMASK,
      `HAMD_OFS_ENDIAN, `HAMD_OFS_HWCFG, `HAMD_OFS_PMT, `HAMD_OFS_TCFG,
      `HAMD_OFS_TCNT, `HAMD_OFS_FREE, `HAMD_OFS_RSTCTL:
        sys_known = 1'b1;
      `HAMD_OFS_CDATA, `HAMD_OFS_CCMD, `HAMD_OFS_PRD_AL, `HAMD_OFS_PRD_CMD,
      `HAMD_OFS_PWR_AL, `HAMD_OFS_PWR_CMD:
        sys_known = !dm;
      default:
        sys_known = 1'b0;
    endcase
  endfunction : sys_known

  //////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [`HAMD_STRAP_W-1:0] strap_meta_reg;    // First synchroniser stage.
  logic [`HAMD_STRAP_W-1:0] strap_sync_reg;    // Second synchroniser stage.
  logic [1:0]               rst_cnt_reg;       // Cycles since reset release.
  logic                     direct_mode_reg;   // Mode flag.
  logic [31:0]              irq_cfg_reg;       // Interrupt pin configuration.
  logic [31:0]              iflags_reg;        // Sticky event flags.
  logic [31:0]              imask_reg;         // Event mask.
  logic [31:0]              pmt_reg;           // Power management control.
  logic [31:0]              tcfg_reg;          // Timer reload and enable.
  logic [31:0]              tcnt_reg;          // Timer down-counter.
  logic [31:0]              free_reg;          // Free-running counter.
  logic [31:0]              cdata_reg;         // Core indirect data.
  logic [31:0]              ccmd_reg;          // Core indirect command.
  logic [31:0]              prd_al_reg;        // RAM read address and length.
  logic [31:0]              prd_cmd_reg;       // RAM read command.
  logic [31:0]              pwr_al_reg;        // RAM write address and length.
  logic [31:0]              pwr_cmd_reg;       // RAM write command.
  logic                     ext_pend_reg;      // Core access in flight.

  hamd_pkg::hamd_target_type tgt;              // Target of the current request.
  logic [11:0]               off;              // System offset, mode removed.
  logic [31:0]               sys_rdata;        // System register read value.
  logic                      take;             // Request accepted this cycle.
  logic                      sys_wr;           // System register write strobe.
  logic                      capture_now;      // Strap capture strobe.

  // Both host ports feed this one request path, so offsets match exactly.
  assign take   = host_req_in && !ext_pend_reg;
  assign tgt    = decode(host_cmd_in.addr, direct_mode_reg);
  assign off    = direct_mode_reg ? 12'(host_cmd_in.addr - `HAMD_SYS_BASE)
                                  : host_cmd_in.addr[11:0];
  assign sys_wr = take && host_cmd_in.wr && tgt == hamd_pkg::TGT_SYS;
  // Capture at the third edge after release: only then does the second
  // synchroniser stage hold the pin levels rather than its reset value.
  assign capture_now = (rst_cnt_reg == `HAMD_STRAP_DELAY) ||
                       core_reset_in || core_reset_out;

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture.

  // Pins are asynchronous, so they pass two flops before any use.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end
    else
    begin
      strap_meta_reg <= strap_pins_in;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // The latch takes levels after release, never through the async reset.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_cnt_reg <= 2'h0;
      strap_out   <= '0;
    end
    else
    begin
      // The counter parks one past the capture count so the strobe fires once.
      if (rst_cnt_reg != `HAMD_STRAP_DELAY + 2'h1)
        rst_cnt_reg <= rst_cnt_reg + 2'h1;
      if (capture_now)
        strap_out <= strap_sync_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read multiplexer for system registers.

  // Reserved offsets read zero.
  always_comb
  begin
    case (off)
      `HAMD_OFS_ID:      sys_rdata = `HAMD_CHIP_ID;
      `HAMD_OFS_IRQCFG:  sys_rdata = irq_cfg_reg;
      `HAMD_OFS_IFLAGS:  sys_rdata = iflags_reg;
      `HAMD_OFS_IMASK:   sys_rdata = imask_reg;
      `HAMD_OFS_ENDIAN:  sys_rdata = `HAMD_ENDIAN_PAT;
      `HAMD_OFS_HWCFG:   sys_rdata = {12'h000, strap_out, 15'h0000,
                                      direct_mode_reg};
      `HAMD_OFS_PMT:     sys_rdata = pmt_reg;
      `HAMD_OFS_TCFG:    sys_rdata = tcfg_reg;
      `HAMD_OFS_TCNT:    sys_rdata = tcnt_reg;
      `HAMD_OFS_FREE:    sys_rdata = free_reg;
      `HAMD_OFS_CDATA:   sys_rdata = cdata_reg;
      `HAMD_OFS_CCMD:    sys_rdata = ccmd_reg;
      `HAMD_OFS_PRD_AL:  sys_rdata = prd_al_reg;
      `HAMD_OFS_PRD_CMD: sys_rdata = prd_cmd_reg;
      `HAMD_OFS_PWR_AL:  sys_rdata = pwr_al_reg;
      `HAMD_OFS_PWR_CMD: sys_rdata = pwr_cmd_reg;
      default:           sys_rdata = `HAMD_ZERO32;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host answer path.

  // Local targets answer one cycle after the request; a core access is
  // forwarded first and answered one cycle after that.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      host_ack_out     <= 1'b0;
      host_rdata_out   <= `HAMD_ZERO32;
      rd_fifo_pop_out  <= 1'b0;
      wr_fifo_push_out <= 1'b0;
      wr_fifo_data_out <= `HAMD_ZERO32;
      core_req_out     <= 1'b0;
      core_cmd_out     <= '0;
      ext_pend_reg     <= 1'b0;
    end
    else
    begin
      host_ack_out     <= 1'b0;
      rd_fifo_pop_out  <= 1'b0;
      wr_fifo_push_out <= 1'b0;
      core_req_out     <= 1'b0;
      if (ext_pend_reg)
      begin
        // Core data is valid while the forwarded request stands.
        ext_pend_reg   <= 1'b0;
        host_ack_out   <= 1'b1;
        host_rdata_out <= core_cmd_out.wr ? `HAMD_ZERO32 : core_rdata_in;
      end
      else if (take)
      begin
        case (tgt)
          hamd_pkg::TGT_CORE, hamd_pkg::TGT_PRAM:
          begin
            core_req_out       <= 1'b1;
            ext_pend_reg       <= 1'b1;
            core_cmd_out.wr    <= host_cmd_in.wr;
            core_cmd_out.pram  <= (tgt == hamd_pkg::TGT_PRAM);
            core_cmd_out.addr  <= host_cmd_in.addr;
            core_cmd_out.wdata <= host_cmd_in.wdata;
          end
          hamd_pkg::TGT_RD_FIFO:
          begin
            host_ack_out    <= 1'b1;
            host_rdata_out  <= host_cmd_in.wr ? `HAMD_ZERO32 : rd_fifo_data_in;
            rd_fifo_pop_out <= !host_cmd_in.wr;
          end
          hamd_pkg::TGT_WR_FIFO:
          begin
            host_ack_out     <= 1'b1;
            host_rdata_out   <= `HAMD_ZERO32;
            wr_fifo_push_out <= host_cmd_in.wr;
            wr_fifo_data_out <= host_cmd_in.wdata;
          end
          hamd_pkg::TGT_SYS:
          begin
            host_ack_out   <= 1'b1;
            host_rdata_out <= host_cmd_in.wr ? `HAMD_ZERO32 : sys_rdata;
          end
          default:
          begin
            host_ack_out   <= 1'b1;
            host_rdata_out <= `HAMD_ZERO32;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode flag and plain control registers.

  // Every register returns to its default on chip reset.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      direct_mode_reg <= 1'b0;
      irq_cfg_reg     <= `HAMD_ZERO32;
      imask_reg       <= `HAMD_ZERO32;
      pmt_reg         <= `HAMD_ZERO32;
      cdata_reg       <= `HAMD_ZERO32;
      prd_al_reg      <= `HAMD_ZERO32;
      pwr_al_reg      <= `HAMD_ZERO32;
    end
    else if (sys_wr)
    begin
      case (off)
        `HAMD_OFS_HWCFG:
          direct_mode_reg <= host_cmd_in.wdata[`HAMD_HWCFG_DIRECT];
        `HAMD_OFS_IRQCFG: irq_cfg_reg <= host_cmd_in.wdata;
        `HAMD_OFS_IMASK:  imask_reg   <= host_cmd_in.wdata;
        `HAMD_OFS_PMT:    pmt_reg     <= host_cmd_in.wdata;
        `HAMD_OFS_CDATA:  cdata_reg   <= host_cmd_in.wdata;
        `HAMD_OFS_PRD_AL: prd_al_reg  <= host_cmd_in.wdata;
        `HAMD_OFS_PWR_AL: pwr_al_reg  <= host_cmd_in.wdata;
        default:          ;
      endcase
    end
  end

  // Sticky flags: write one clears, and a same-cycle event keeps its bit.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      iflags_reg <= `HAMD_ZERO32;
    else if (sys_wr && off == `HAMD_OFS_IFLAGS)
      iflags_reg <= (iflags_reg & ~host_cmd_in.wdata) | int_event_in;
    else
      iflags_reg <= iflags_reg | int_event_in;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Indirect commands; busy set by the host, cleared by the engine.

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ccmd_reg          <= `HAMD_ZERO32;
      prd_cmd_reg       <= `HAMD_ZERO32;
      pwr_cmd_reg       <= `HAMD_ZERO32;
      ind_cmd_start_out <= 1'b0;
      pram_rd_start_out <= 1'b0;
      pram_wr_start_out <= 1'b0;
    end
    else
    begin
      ind_cmd_start_out <= sys_wr && off == `HAMD_OFS_CCMD &&
                           host_cmd_in.wdata[`HAMD_CMD_BUSY];
      pram_rd_start_out <= sys_wr && off == `HAMD_OFS_PRD_CMD &&
                           host_cmd_in.wdata[`HAMD_CMD_BUSY];
      pram_wr_start_out <= sys_wr && off == `HAMD_OFS_PWR_CMD &&
                           host_cmd_in.wdata[`HAMD_CMD_BUSY];
      // A host write wins over a completion in the same cycle.
      if (sys_wr && off == `HAMD_OFS_CCMD)
        ccmd_reg <= host_cmd_in.wdata;
      else if (ind_cmd_done_in)
        ccmd_reg[`HAMD_CMD_BUSY] <= 1'b0;
      if (sys_wr && off == `HAMD_OFS_PRD_CMD)
        prd_cmd_reg <= host_cmd_in.wdata;
      else if (pram_rd_done_in)
        prd_cmd_reg[`HAMD_CMD_BUSY] <= 1'b0;
      if (sys_wr && off == `HAMD_OFS_PWR_CMD)
        pwr_cmd_reg <= host_cmd_in.wdata;
      else if (pram_wr_done_in)
        pwr_cmd_reg[`HAMD_CMD_BUSY] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timer, free-running counter and core reset request.

  // The counters tick at the system clock; no separate 25 MHz domain here.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tcfg_reg       <= `HAMD_TCFG_RST;
      tcnt_reg       <= `HAMD_TCFG_RST;
      free_reg       <= `HAMD_ZERO32;
      core_reset_out <= 1'b0;
    end
    else
    begin
      free_reg       <= free_reg + 32'h0000_0001;
      core_reset_out <= sys_wr && off == `HAMD_OFS_RSTCTL &&
                        host_cmd_in.wdata[`HAMD_RSTCTL_CORE];
      if (sys_wr && off == `HAMD_OFS_TCFG)
      begin
        tcfg_reg <= host_cmd_in.wdata;
        tcnt_reg <= {16'h0000, host_cmd_in.wdata[15:0]};
      end
      else if (tcfg_reg[`HAMD_TCFG_EN])
        tcnt_reg <= (tcnt_reg == `HAMD_ZERO32) ? {16'h0000, tcfg_reg[15:0]}
                                               : tcnt_reg - 32'h0000_0001;
    end
  end

  // Registered copy of the mode flag for the rest of the chip.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      direct_mode_out <= 1'b0;
    else
      direct_mode_out <= direct_mode_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  a_local_answer: assert property (take && tgt != hamd_pkg::TGT_CORE &&
    tgt != hamd_pkg::TGT_PRAM |=> host_ack_out && !core_req_out)
    else $error("local access not answered next cycle");
  a_core_forward: assert property (take && (tgt == hamd_pkg::TGT_CORE ||
    tgt == hamd_pkg::TGT_PRAM) |=> core_req_out && !host_ack_out ##1 host_ack_out)
    else $error("core access not forwarded then answered");
  a_fifo_read_pop: assert property (take && !host_cmd_in.wr && !direct_mode_reg &&
    host_cmd_in.addr <= 16'h001C |=> rd_fifo_pop_out && host_ack_out)
    else $error("read window did not pop");
  a_fifo_write_push: assert property (take && host_cmd_in.wr &&
    !direct_mode_reg && host_cmd_in.addr >= 16'h0020 &&
    host_cmd_in.addr <= 16'h003C |=> wr_fifo_push_out)
    else $error("write window did not push");
  a_direct_hides_fifo: assert property (direct_mode_reg && take |=>
    !rd_fifo_pop_out && !wr_fifo_push_out && !ind_cmd_start_out &&
    !pram_rd_start_out && !pram_wr_start_out)
    else $error("fifo or indirect reached in direct mode");
  a_sys_relocated: assert property (direct_mode_reg && take &&
    !host_cmd_in.wr && host_cmd_in.addr == 16'h3050 |=>
    host_rdata_out == `HAMD_CHIP_ID)
    else $error("identity not found at relocated offset");
  a_unmapped_zero: assert property (take && !host_cmd_in.wr &&
    tgt == hamd_pkg::TGT_NONE |=> host_rdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_mode_follows: assert property (sys_wr && off == `HAMD_OFS_HWCFG |=>
    direct_mode_reg == $past(host_cmd_in.wdata[0]) ##1
    direct_mode_out == $past(direct_mode_reg))
    else $error("mode flag did not follow write");
  a_strap_capture: assert property (capture_now |=>
    strap_out == $past(strap_sync_reg))
    else $error("strap not captured");
  a_flag_set_wins: assert property (int_event_in != 32'h0000_0000 |=>
    (iflags_reg & $past(int_event_in)) == $past(int_event_in))
    else $error("event lost against clear");

  c_direct_core: cover property (take && tgt == hamd_pkg::TGT_CORE ##2 host_ack_out);
  c_fifo_read: cover property (take && tgt == hamd_pkg::TGT_RD_FIFO);
  c_mode_switch: cover property ($rose(direct_mode_reg));

endmodule : hamd_host_address_map_decoder

`default_nettype wire

// *** design/hamd_pkg.sv ***
package hamd_pkg;

  // Where a host access lands after decoding.
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_RD_FIFO,
    TGT_WR_FIFO,
    TGT_SYS,
    TGT_CORE,
    TGT_PRAM
  } hamd_target_type;

  // One host access as handed over by the host bus or serial port.
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } hamd_req_type;

  // One access forwarded to the slave core in direct-mapped mode.
  typedef struct packed {
    logic        wr;
    logic        pram;
    logic [15:0] addr;
    logic [31:0] wdata;
  } hamd_core_type;

endpackage : hamd_pkg

// *** test/hamd_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far side: slave core, read FIFO head and indirect engines.
module hamd_core_model (
  // Clock and reset.
  input  wire logic                    mclk_in,
  input  wire logic                    resetn_in,
  // Decoder side.
  input  wire logic                    core_req_in,
  input  wire hamd_pkg::hamd_core_type core_cmd_in,
  output logic [31:0]                  core_rdata_out,
  input  wire logic                    pop_in,
  output logic [31:0]                  head_out,
  input  wire logic [2:0]              start_in,
  output logic [2:0]                   done_out
);
  logic [31:0] head_reg; // Word now at the FIFO head.
  logic [2:0]  d1_reg;   // Engines are busy for two cycles.
  // Outside an access the data shows the inverse, so a stale sample never matches.
  assign core_rdata_out = core_req_in ? {15'h0000, core_cmd_in.pram, core_cmd_in.addr}
                                      : ~{15'h0000, core_cmd_in.pram, core_cmd_in.addr};
  assign head_out = head_reg;
  // Each pop moves the next word to the head.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in) head_reg <= 32'h0000_1000;
    else if (pop_in) head_reg <= head_reg + 32'h0000_0001;
  end
  // Completion pulses two cycles after each start.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in) {done_out, d1_reg} <= 6'h00;
    else {done_out, d1_reg} <= {d1_reg, start_in};
  end
endmodule : hamd_core_model
`default_nettype wire

// *** test/host_address_map_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hamd_defs.svh"
module host_address_map_decoder_tb;
  logic clk, rst_n, req, ack, pop, push, creq, cro, dm, crin;
  logic [31:0] rd, rdq, head, crd, pw, ev;
  logic [2:0] st, dn, seen;
  logic [3:0] pins, straps;
  hamd_pkg::hamd_req_type cmd;
  hamd_pkg::hamd_core_type ccmd;
  int mismatches, checked;
  hamd_host_address_map_decoder i_hamd_host_address_map_decoder (
    .mclk_in(clk), .resetn_in(rst_n), .host_req_in(req), .host_cmd_in(cmd),
    .host_ack_out(ack), .host_rdata_out(rd), .rd_fifo_data_in(head),
    .rd_fifo_pop_out(pop), .wr_fifo_push_out(push), .wr_fifo_data_out(pw),
    .core_req_out(creq), .core_cmd_out(ccmd), .core_rdata_in(crd),
    .ind_cmd_start_out(st[0]), .pram_rd_start_out(st[1]), .pram_wr_start_out(st[2]),
    .ind_cmd_done_in(dn[0]), .pram_rd_done_in(dn[1]), .pram_wr_done_in(dn[2]),
    .int_event_in(ev), .core_reset_in(crin), .core_reset_out(cro),
    .strap_pins_in(pins), .strap_out(straps), .direct_mode_out(dm));
  hamd_core_model i_hamd_core_model (
    .mclk_in(clk), .resetn_in(rst_n), .core_req_in(creq), .core_cmd_in(ccmd),
    .core_rdata_out(crd), .pop_in(pop), .head_out(head), .start_in(st), .done_out(dn));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Remember which indirect engines were started.
  always @(posedge clk) seen <= rst_n ? (seen | st) : 3'h0;
  task automatic print_verdict;
  begin
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
  begin
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  end
  endtask : chk
  // One host access: strobe for one cycle, then wait a bounded time for the ack.
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
  begin
    @(negedge clk);
    req = 1'b1;
    cmd = '{w, a, d};
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 5)
    begin
      @(negedge clk);
      n++;
    end
    if (ack !== 1'b1)
    begin
      mismatches++;
      print_verdict();
    end
    rdq = rd;
  end
  endtask : acc
  initial
  begin
    rst_n = 1'b0; req = 1'b0; cmd = '0; pins = 4'hA; ev = '0; crin = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("strap", {28'h0000000, straps}, 32'h0000_000A);
    acc(1'b0, 16'h0050, 32'h0); chk("id", rdq, `HAMD_CHIP_ID);
    acc(1'b0, 16'h0064, 32'h0); chk("endian", rdq, `HAMD_ENDIAN_PAT);
    acc(1'b0, 16'h008C, 32'h0); chk("tcfg", rdq, `HAMD_TCFG_RST);
    acc(1'b0, 16'h0074, 32'h0); chk("hwcfg", rdq, 32'h000A_0000);
    acc(1'b1, 16'h0040, 32'hFFFF_FFFF);
    acc(1'b0, 16'h0040, 32'h0); chk("unmapped", rdq, 32'h0000_0000);
    acc(1'b0, 16'h0318, 32'h0); chk("past_top", rdq, 32'h0000_0000);
    acc(1'b0, 16'h001C, 32'h0); chk("fifo_hi", rdq, 32'h0000_1000);
    chk("pop", {31'h0, pop}, 32'h0000_0001);
    acc(1'b0, 16'h0000, 32'h0); chk("fifo_lo", rdq, 32'h0000_1001);
    acc(1'b1, 16'h003C, 32'h5A5A_0001); chk("wfifo", pw, 32'h5A5A_0001);
    chk("push", {31'h0, push}, 32'h0000_0001);
    acc(1'b1, 16'h0020, 32'h5A5A_0002); chk("wfifo_lo", pw, 32'h5A5A_0002);
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b1, 16'h0300 + 16'(8 * i), 32'h1234_0000 + i);
      acc(1'b0, 16'h0300 + 16'(8 * i), 32'h0); chk("ind", rdq, 32'h1234_0000 + i);
      acc(1'b1, 16'h0304 + 16'(8 * i), 32'h8000_0000);
    end
    repeat (6) @(negedge clk);
    chk("starts", {29'h0, seen}, 32'h0000_0007);
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b0, 16'h0304 + 16'(8 * i), 32'h0); chk("done", {31'h0, rdq[31]}, 32'h0);
    end
    acc(1'b1, 16'h0074, 32'h0000_0001);
    acc(1'b0, 16'h3050, 32'h0); chk("id_dir", rdq, `HAMD_CHIP_ID);
    chk("dm", {31'h0, dm}, 32'h0000_0001);
    acc(1'b0, 16'h1004, 32'h0); chk("pram", rdq, 32'h0001_1004);
    acc(1'b0, 16'h0FFC, 32'h0); chk("core", rdq, 32'h0000_0FFC);
    acc(1'b0, 16'h3300, 32'h0); chk("ind_gone", rdq, 32'h0);
    acc(1'b0, 16'h3000, 32'h0); chk("fifo_gone", rdq, 32'h0);
    pins = 4'h5;
    acc(1'b1, 16'h31F8, 32'h0000_0001);
    chk("core_rst", {31'h0, cro}, 32'h0000_0001);
    repeat (4) @(negedge clk);
    chk("restrap", {28'h0000000, straps}, 32'h0000_0005);
    acc(1'b1, 16'h3074, 32'h0);
    acc(1'b0, 16'h0050, 32'h0); chk("id_back", rdq, `HAMD_CHIP_ID);
    acc(1'b1, 16'h005C, 32'hFFFF_FFFF);
    acc(1'b0, 16'h005C, 32'h0); chk("mask", rdq, 32'hFFFF_FFFF);
    // Bit 2 pulses again in the clearing cycle, so it must survive the clear.
    @(negedge clk);
    ev = 32'h0000_0007;
    @(negedge clk);
    ev = 32'h0000_0004;
    acc(1'b1, 16'h0058, 32'h0000_0007);
    ev = '0;
    acc(1'b0, 16'h0058, 32'h0); chk("flag_keep", rdq, 32'h0000_0004);
    // A core reset pulse recaptures the synchronised pins.
    pins = 4'h3;
    repeat (3) @(negedge clk);
    crin = 1'b1;
    @(negedge clk);
    crin = 1'b0;
    @(negedge clk);
    chk("core_restrap", {28'h0000000, straps}, 32'h0000_0003);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    acc(1'b0, 16'h005C, 32'h0); chk("mask_rst", rdq, 32'h0);
    chk("dm_rst", {31'h0, dm}, 32'h0);
    chk("strap_rst", {28'h0000000, straps}, 32'h0000_0003);
    print_verdict();
  end
endmodule : host_address_map_decoder_tb
`default_nettype wire
